// File: mds_datapath.sv
// destination steering, shift/program counters, keys, operand shifter, next address
//
// Operation
// - gr write bit with class 0X writes result into register picked by a_select
// - special dest: 001 pc, 010 shift counter, 011/111 operand, 110 proc key
// - one microinstruction may load a general and a special register together
// - sequence not 00: XX1X drives data bus, 01XX loads address, if cycle starts
// - sequence 00, memory-op 0100 loads memory input register and instruction buffer
// - sequence 00, memory-op 111X sends result to I/O register under I/O control
// - 8-bit shift counter increments and tests without the arithmetic unit
// - overflow true while counter is all ones; test sees pre-increment value
// - 16-bit pc increments alone; increment plus memory use gives new address
// - four-bit processor key goes to map with high address on processor ops
// - four-bit I/O key goes to map on ops started by I/O control
// - operand register shifts only when class is 0X, never with literal/mask
// - shift bit 0 holds; 1 shifts one place, left on direction 0, right on 1
// - left fill: own bit 15, gr bit 15, not result bit 15, zero
// - right fill: own bit 0, gr bit 0, own bit 15, shift flag
// - operand shift works alone or together with a shifted general register
// - every microinstruction gives the next address; no hardware increment
// - normal addressing: bits 0-3 from mask-low, bits 4-8 from address field
// - secondary field ORed into address bits 1 to 4 unless excluded
// - OR-in suppressed on extraction, interrupts allowed, I/O request, page jump
// - decode addressing takes next address from instruction buffer via decoder
// - zero mask bits clear address contribution; mask-high zero on I/O request
`timescale 1ns/10ps
`include "mds_params.svh"

module mds_datapath (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [15:0] alu_result,
   input wire logic gr_write_bit,
   input wire logic [1:0] b_source_class,
   input wire logic [3:0] a_register_select,
   input wire logic [2:0] special_dest_select,
   input wire logic [1:0] sequence_field,
   input wire logic [3:0] memory_op_field,
   input wire logic mem_cycle_start,
   input wire logic io_transfer,
   input wire logic io_mem_op,
   input wire logic sc_increment,
   input wire logic pc_increment,
   input wire logic pc_as_mem_addr,
   input wire logic shift_control_bit,
   input wire logic shift_direction_bit,
   input wire logic [1:0] shift_fill_select,
   input wire logic shift_flag,
   input wire logic [3:0] field_select,
   input wire logic [3:0] secondary_address_field,
   input wire logic mask_high_bit,
   input wire logic [3:0] mask_low_field,
   input wire logic [4:0] address_field,
   input wire logic [1:0] register_extract_field,
   input wire logic [1:0] test_field,
   input wire logic [3:0] condition_field,
   input wire logic decode_select,
   input wire logic [8:0] decoder_store_addr,
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata_q,
   output logic [15:0] gr_a_q,
   output logic [15:0] pc_q,
   output logic [7:0] shift_count_q,
   output logic sc_overflow_q,
   output logic [15:0] operand_q,
   output logic [3:0] proc_key_q,
   output logic [3:0] io_key_q,
   output logic [15:0] mem_data_q,
   output logic mem_data_en_q,
   output logic [15:0] mar_q,
   output logic [15:0] mem_addr_q,
   output logic [3:0] map_key_q,
   output logic [3:0] map_high_q,
   output logic [15:0] mir_q,
   output logic [15:0] ibuf_q,
   output logic [15:0] ior_q,
   output logic io_request_q,
   output logic [8:0] next_addr_q
);

   mds_pkg::mds_word_t gpr [16];
   mds_pkg::mds_word_t gr_sel;
   mds_pkg::mds_word_t pc_d;
   mds_pkg::mds_word_t mar_d;
   mds_pkg::mds_count_t sc_d;
   mds_pkg::mds_caddr_t normal_addr;
   mds_pkg::mds_caddr_t next_addr_d;
   logic no_literal;
   logic io_req;
   logic ts_block;
   logic mh_eff;
   logic fill_bit;
   logic [3:0] ts_term;

   assign gr_sel = gpr[a_register_select];
   assign no_literal = ~b_source_class[1];
   assign io_req = (sequence_field == `MDS_SF_ZERO)
                   && (memory_op_field[3:1] == `MDS_IM_IO_HI);

   generate
      for (genvar i = 0; i < 16; i++) begin : g_gpr
         always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
               gpr[i] <= `MDS_WORD_RST;
            end else if (gr_write_bit && no_literal
                         && (a_register_select == 4'(i))) begin
               gpr[i] <= alu_result;
            end
         end
      end
   endgenerate

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         gr_a_q <= `MDS_WORD_RST;
      end else begin
         gr_a_q <= gr_sel;
      end
   end

   always_comb begin
      pc_d = pc_q;
      if (special_dest_select == `MDS_RF_PC) begin
         pc_d = alu_result;
      end else if (pc_increment) begin
         pc_d = pc_q + `MDS_PC_ONE;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pc_q <= `MDS_WORD_RST;
      end else begin
         pc_q <= pc_d;
      end
   end

   always_comb begin
      sc_d = shift_count_q;
      if (special_dest_select == `MDS_RF_SHCNT) begin
         sc_d = alu_result[7:0];
      end else if (sc_increment) begin
         sc_d = shift_count_q + `MDS_SC_ONE;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         shift_count_q <= 8'h00;
         sc_overflow_q <= 1'b0;
      end else begin
         shift_count_q <= sc_d;
         sc_overflow_q <= (sc_d == `MDS_SC_ONES);
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         proc_key_q <= `MDS_KEY_RST;
      end else if (special_dest_select == `MDS_RF_PKEY) begin
         proc_key_q <= alu_result[3:0];
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         io_key_q <= `MDS_KEY_RST;
      end else if (reg_wr && (reg_addr == `MDS_REG_KEYS)) begin
         io_key_q <= reg_wdata[`MDS_KEYS_IO_LSB +: 4];
      end
   end

   always_comb begin
      fill_bit = 1'b0;
      if (!shift_direction_bit) begin
         case (shift_fill_select)
            `MDS_XF_OWN: fill_bit = operand_q[`MDS_MSB];
            `MDS_XF_GPR: fill_bit = gr_sel[`MDS_MSB];
            `MDS_XF_ALT: fill_bit = ~alu_result[`MDS_MSB];
            default: fill_bit = 1'b0;
         endcase
      end else begin
         case (shift_fill_select)
            `MDS_XF_OWN: fill_bit = operand_q[0];
            `MDS_XF_GPR: fill_bit = gr_sel[0];
            `MDS_XF_ALT: fill_bit = operand_q[`MDS_MSB];
            default: fill_bit = shift_flag;
         endcase
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         operand_q <= `MDS_WORD_RST;
      end else if ((special_dest_select == `MDS_RF_OPREG_A)
                   || (special_dest_select == `MDS_RF_OPREG_B)) begin
         operand_q <= alu_result;
      end else if (no_literal && shift_control_bit) begin
         if (!shift_direction_bit) begin
            operand_q <= {operand_q[14:0], fill_bit};
         end else begin
            operand_q <= {fill_bit, operand_q[15:1]};
         end
      end
   end

   assign mar_d = (sequence_field != `MDS_SF_ZERO) && mem_cycle_start
                  && (memory_op_field[3:2] == `MDS_IM_MAR_HI)
                  ? alu_result : mar_q;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         mem_data_q <= `MDS_WORD_RST;
         mem_data_en_q <= 1'b0;
         mar_q <= `MDS_WORD_RST;
      end else begin
         mar_q <= mar_d;
         mem_data_en_q <= 1'b0;
         if ((sequence_field != `MDS_SF_ZERO) && mem_cycle_start
             && memory_op_field[`MDS_IM_DATA_BIT]) begin
            mem_data_q <= alu_result;
            mem_data_en_q <= 1'b1;
         end
      end
   end

   // I/O key on I/O control ops
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         mem_addr_q <= `MDS_WORD_RST;
         map_key_q <= `MDS_KEY_RST;
         map_high_q <= `MDS_KEY_RST;
      end else begin
         mem_addr_q <= pc_as_mem_addr ? pc_d : mar_d;
         map_key_q <= io_mem_op ? io_key_q : proc_key_q;
         map_high_q <= pc_as_mem_addr ? pc_d[`MDS_MAP_HI_LSB +: 4]
                                      : mar_d[`MDS_MAP_HI_LSB +: 4];
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         mir_q <= `MDS_WORD_RST;
         ibuf_q <= `MDS_WORD_RST;
      end else if ((sequence_field == `MDS_SF_ZERO)
                   && (memory_op_field == `MDS_IM_MIR)) begin
         mir_q <= alu_result;
         ibuf_q <= alu_result;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ior_q <= `MDS_WORD_RST;
         io_request_q <= 1'b0;
      end else begin
         io_request_q <= io_req;
         if (io_req && io_transfer) begin
            ior_q <= alu_result;
         end
      end
   end

   assign ts_block = (register_extract_field == `MDS_AB_EXTR_A)
      || (register_extract_field == `MDS_AB_EXTR_B)
      || ((sequence_field == `MDS_SF_ZERO) && (test_field == `MDS_TF_NONE)
          && condition_field[`MDS_GF_PAGE_BIT])
      || io_req
      || ((test_field == `MDS_TF_NONE) && (sequence_field == `MDS_SF_PAGE)
          && condition_field[`MDS_GF_PAGE_BIT]);

   assign mh_eff = mask_high_bit && !io_req;
   assign ts_term = ts_block ? 4'h0 : secondary_address_field;

   always_comb begin
      normal_addr = {address_field, 4'h0};
      normal_addr = normal_addr | {4'h0, mh_eff, mask_low_field};
      normal_addr = normal_addr | {4'h0, ts_term, 1'b0};
   end

   assign next_addr_d = decode_select ? decoder_store_addr : normal_addr;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         next_addr_q <= `MDS_ADDR_RST;
      end else begin
         next_addr_q <= next_addr_d;
      end
   end

   // register port read, one cycle later
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         reg_rdata_q <= `MDS_WORD_RST;
      end else if (reg_rd) begin
         if (reg_addr == `MDS_REG_PC) begin
            reg_rdata_q <= pc_q;
         end else if (reg_addr == `MDS_REG_SHCNT) begin
            reg_rdata_q <= {8'h00, shift_count_q};
         end else if (reg_addr == `MDS_REG_OPREG) begin
            reg_rdata_q <= operand_q;
         end else if (reg_addr == `MDS_REG_KEYS) begin
            reg_rdata_q <= {8'h00, io_key_q, proc_key_q};
         end else if (reg_addr == `MDS_REG_NEXT) begin
            reg_rdata_q <= {7'h00, next_addr_q};
         end else if (reg_addr == `MDS_REG_STATUS) begin
            reg_rdata_q <= {14'h0000, io_request_q, sc_overflow_q};
         end else begin
            reg_rdata_q <= `MDS_WORD_RST;
         end
      end else begin
         reg_rdata_q <= `MDS_WORD_RST;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   chk_gpr_write: assert property (
      gr_write_bit && !b_source_class[1] |-> ##2 gr_a_q == $past(alu_result, 2)
         || $past(a_register_select) != $past(a_register_select, 2))
      else $error("general register write lost");

   chk_pc_load: assert property (
      special_dest_select == `MDS_RF_PC |=> pc_q == $past(alu_result))
      else $error("program counter not loaded");

   chk_sc_overflow: assert property (
      sc_overflow_q == (shift_count_q == `MDS_SC_ONES))
      else $error("shift counter overflow wrong");

   chk_sc_count: assert property (
      sc_increment && special_dest_select != `MDS_RF_SHCNT
      |=> shift_count_q == $past(shift_count_q) + `MDS_SC_ONE)
      else $error("shift counter not incremented");

   chk_pc_addr: assert property (
      pc_increment && pc_as_mem_addr && special_dest_select != `MDS_RF_PC
      |=> mem_addr_q == pc_q && pc_q == $past(pc_q) + `MDS_PC_ONE)
      else $error("memory address not new pc");

   chk_op_hold: assert property (
      b_source_class[1] && special_dest_select != `MDS_RF_OPREG_A
      && special_dest_select != `MDS_RF_OPREG_B |=> $stable(operand_q))
      else $error("operand shifted with literal");

   chk_op_left: assert property (
      !b_source_class[1] && shift_control_bit && !shift_direction_bit
      && shift_fill_select == `MDS_XF_LAST
      && special_dest_select[1:0] != 2'h3
      |=> operand_q == {$past(operand_q[14:0]), 1'b0})
      else $error("left zero fill wrong");

   chk_op_right: assert property (
      !b_source_class[1] && shift_control_bit && shift_direction_bit
      && shift_fill_select == `MDS_XF_ALT
      && special_dest_select[1:0] != 2'h3
      |=> operand_q[15:14] == {2{$past(operand_q[15])}})
      else $error("arithmetic right shift wrong");

   chk_data_bus: assert property (
      sequence_field != `MDS_SF_ZERO && memory_op_field[1] && mem_cycle_start
      |=> mem_data_en_q && mem_data_q == $past(alu_result))
      else $error("memory data bus not driven");

   chk_map_key: assert property (
      !io_mem_op |=> map_key_q == $past(proc_key_q))
      else $error("processor key not sent to map");

   chk_next_decode: assert property (
      decode_select |=> next_addr_q == $past(decoder_store_addr))
      else $error("decode address not taken");

   chk_next_ts: assert property (
      io_req && !decode_select
      |=> next_addr_q[4:1] == $past({address_field[0], mask_low_field[3:1]}))
      else $error("secondary field not suppressed");

   cov_multi_dest: cover property (
      gr_write_bit && !b_source_class[1] && special_dest_select != 3'h0);
   cov_sc_wrap: cover property (sc_overflow_q && sc_increment);
   cov_double_shift: cover property (
      shift_control_bit && !b_source_class[1]
      && shift_fill_select == `MDS_XF_GPR);

endmodule : mds_datapath

// File: mds_params.svh
// constants for the microinstruction destination, shift and next-address block
`ifndef MDS_PARAMS_SVH
`define MDS_PARAMS_SVH
// special destination codes
`define MDS_RF_PC 3'h1
`define MDS_RF_SHCNT 3'h2
`define MDS_RF_OPREG_A 3'h3
`define MDS_RF_OPREG_B 3'h7
`define MDS_RF_PKEY 3'h6
// sequence and memory-op codes
`define MDS_SF_ZERO 2'h0
`define MDS_SF_PAGE 2'h2
`define MDS_IM_MIR 4'h4
`define MDS_IM_DATA_BIT 1
`define MDS_IM_MAR_HI 2'h1
`define MDS_IM_IO_HI 3'h7
// test, condition and extract codes
`define MDS_TF_NONE 2'h0
`define MDS_GF_PAGE_BIT 2
`define MDS_AB_EXTR_A 2'h1
`define MDS_AB_EXTR_B 2'h2
`define MDS_FS_NORMAL 4'h0
// shift fill select codes
`define MDS_XF_OWN 2'h0
`define MDS_XF_GPR 2'h1
`define MDS_XF_ALT 2'h2
`define MDS_XF_LAST 2'h3
// widths and reset values
`define MDS_MSB 15
`define MDS_SC_ONES 8'hff
`define MDS_SC_ONE 8'h01
`define MDS_PC_ONE 16'h0001
`define MDS_WORD_RST 16'h0000
`define MDS_ADDR_RST 9'h000
`define MDS_KEY_RST 4'h0
`define MDS_MAP_HI_LSB 12
// register port offsets
`define MDS_REG_PC 4'h0
`define MDS_REG_SHCNT 4'h1
`define MDS_REG_OPREG 4'h2
`define MDS_REG_KEYS 4'h3
`define MDS_REG_NEXT 4'h4
`define MDS_REG_STATUS 4'h5
`define MDS_KEYS_IO_LSB 4
`endif

// File: mds_pkg.sv
// types for the microinstruction destination, shift and next-address block
package mds_pkg;
   typedef logic [15:0] mds_word_t;
   typedef logic [8:0] mds_caddr_t;
   typedef logic [3:0] mds_key_t;
   typedef logic [7:0] mds_count_t;
endpackage : mds_pkg

// File: mds_far.sv
// far-side model: memory/io control acceptance and the decoder store
`timescale 1ns/10ps
module mds_far (
   input wire logic [15:0] ibuf_q,
   input wire logic [1:0] sequence_field,
   input wire logic [3:0] memory_op_field,
   input wire logic mem_busy,
   output logic mem_cycle_start,
   output logic io_transfer,
   output logic [8:0] decoder_store_addr
);
   assign mem_cycle_start = (sequence_field != 2'h0) && !mem_busy
      && (memory_op_field[1] || (memory_op_field[3:2] == 2'h1));
   assign io_transfer = (sequence_field == 2'h0) && !mem_busy
      && (memory_op_field[3:1] == 3'h7);
   assign decoder_store_addr = ~ibuf_q[8:0];
endmodule : mds_far

// File: mds_datapath_tb.sv
// self-checking bench for the destination, shift and next-address block
`timescale 1ns/10ps
module mds_datapath_tb;
   typedef struct packed {
      logic [3:0] ms;
      logic mt;
      logic [4:0] af;
      logic [3:0] ts;
      logic [1:0] ab;
      logic [1:0] sf;
      logic [3:0] im;
      logic [1:0] tf;
      logic [3:0] gf;
      logic [8:0] na;
   } mds_row_s;
   mds_row_s rows [11] = '{
      '{4'h5, 1'b0, 5'h0a, 4'h0, 2'h0, 2'h0, 4'h0, 2'h0, 4'h0, 9'h0a5},
      '{4'hf, 1'b0, 5'h1f, 4'hf, 2'h0, 2'h0, 4'h0, 2'h0, 4'h0, 9'h1ff},
      '{4'h0, 1'b0, 5'h01, 4'h5, 2'h0, 2'h0, 4'h0, 2'h0, 4'h0, 9'h01a},
      '{4'h1, 1'b0, 5'h02, 4'h5, 2'h1, 2'h0, 4'h0, 2'h0, 4'h0, 9'h021},
      '{4'h1, 1'b0, 5'h02, 4'h5, 2'h2, 2'h0, 4'h0, 2'h0, 4'h0, 9'h021},
      '{4'h0, 1'b0, 5'h03, 4'h3, 2'h0, 2'h0, 4'h0, 2'h0, 4'h4, 9'h030},
      '{4'h2, 1'b1, 5'h04, 4'h3, 2'h0, 2'h0, 4'he, 2'h0, 4'h0, 9'h042},
      '{4'h0, 1'b0, 5'h05, 4'h6, 2'h0, 2'h2, 4'h0, 2'h0, 4'h4, 9'h050},
      '{4'h0, 1'b1, 5'h00, 4'h0, 2'h0, 2'h0, 4'h0, 2'h0, 4'h0, 9'h010},
      '{4'h0, 1'b0, 5'h00, 4'h1, 2'h0, 2'h0, 4'hf, 2'h0, 4'h0, 9'h000},
      '{4'h0, 1'b0, 5'h00, 4'h2, 2'h0, 2'h1, 4'h0, 2'h0, 4'h4, 9'h004}};
   logic [15:0] shx [8] = '{16'h8004, 16'h8005, 16'h8005, 16'h8004,
      16'h2001, 16'ha001, 16'h2001, 16'ha001};
   logic clk, arst_n, gr_write_bit, mem_busy, io_mem_op, decode_select;
   logic sc_increment, pc_increment, pc_as_mem_addr, mask_high_bit;
   logic shift_control_bit, shift_direction_bit, shift_flag, reg_wr, reg_rd;
   logic [15:0] alu_result, reg_wdata;
   logic [3:0] a_register_select, memory_op_field, secondary_address_field;
   logic [3:0] mask_low_field, condition_field, reg_addr;
   logic [2:0] special_dest_select;
   logic [1:0] b_source_class, sequence_field, shift_fill_select;
   logic [1:0] register_extract_field, test_field;
   logic [4:0] address_field;
   wire logic mem_cycle_start, io_transfer;
   wire logic [8:0] decoder_store_addr, next_addr_q;
   wire logic [15:0] reg_rdata_q, gr_a_q, pc_q, operand_q, mem_data_q, mar_q;
   wire logic [15:0] mem_addr_q, mir_q, ibuf_q, ior_q;
   wire logic [7:0] shift_count_q;
   wire logic [3:0] proc_key_q, io_key_q, map_key_q, map_high_q;
   wire logic sc_overflow_q, mem_data_en_q, io_request_q;
   int n_mismatch;
   int n_tests;

   mds_datapath mds_datapath_inst (.clk, .arst_n, .alu_result, .gr_write_bit,
      .b_source_class, .a_register_select, .special_dest_select,
      .sequence_field, .memory_op_field, .mem_cycle_start, .io_transfer,
      .io_mem_op, .sc_increment, .pc_increment, .pc_as_mem_addr,
      .shift_control_bit, .shift_direction_bit, .shift_fill_select,
      .shift_flag, .field_select(4'h0), .secondary_address_field,
      .mask_high_bit, .mask_low_field, .address_field,
      .register_extract_field, .test_field, .condition_field,
      .decode_select, .decoder_store_addr, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata_q, .gr_a_q, .pc_q, .shift_count_q, .sc_overflow_q,
      .operand_q, .proc_key_q, .io_key_q, .mem_data_q, .mem_data_en_q,
      .mar_q, .mem_addr_q, .map_key_q, .map_high_q, .mir_q, .ibuf_q, .ior_q,
      .io_request_q, .next_addr_q);
   mds_far mds_far_inst (.ibuf_q, .sequence_field, .memory_op_field,
      .mem_busy, .mem_cycle_start, .io_transfer, .decoder_store_addr);

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task stop_test;
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : stop_test

   // harmless microinstruction between tests
   task idle;
      gr_write_bit <= 1'b0;
      special_dest_select <= 3'h0;
      sequence_field <= 2'h0;
      memory_op_field <= 4'h0;
      sc_increment <= 1'b0;
      pc_increment <= 1'b0;
      pc_as_mem_addr <= 1'b0;
      shift_control_bit <= 1'b0;
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      decode_select <= 1'b0;
      b_source_class <= 2'h0;
      register_extract_field <= 2'h0;
      test_field <= 2'h0;
      condition_field <= 4'h0;
      secondary_address_field <= 4'h0;
      mask_high_bit <= 1'b0;
      io_mem_op <= 1'b0;
      mem_busy <= 1'b0;
   endtask : idle

   // one edge takes the word, then settle
   task op;
      @(posedge clk);
      idle();
      @(negedge clk);
   endtask : op

   task ld(input logic [2:0] d, input logic [15:0] v);
      @(posedge clk);
      special_dest_select <= d;
      alu_result <= v;
      op();
   endtask : ld

   task uop(input logic [1:0] s, input logic [3:0] m, input logic b,
      input logic [15:0] v);
      @(posedge clk);
      sequence_field <= s;
      memory_op_field <= m;
      mem_busy <= b;
      alu_result <= v;
      op();
   endtask : uop

   task reg_op(input logic w, input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= w;
      reg_rd <= !w;
      op();
   endtask : reg_op

   initial begin
      #100us;
      n_mismatch++;
      stop_test();
   end

   initial begin
      arst_n = 1'b0;
      n_mismatch = 0;
      n_tests = 0;
      a_register_select = 4'h3;
      alu_result = 16'h0000;
      shift_direction_bit = 1'b0;
      shift_fill_select = 2'h0;
      shift_flag = 1'b1;
      mask_low_field = 4'h0;
      address_field = 5'h00;
      reg_addr = 4'h0;
      reg_wdata = 16'h0000;
      idle();
      repeat (6) @(posedge clk);
      @(negedge clk);
      check({next_addr_q, pc_q, shift_count_q}, 32'h0000_0000);
      @(posedge clk);
      arst_n <= 1'b1;
      foreach (rows[i]) begin
         @(posedge clk);
         mask_low_field <= rows[i].ms;
         mask_high_bit <= rows[i].mt;
         address_field <= rows[i].af;
         secondary_address_field <= rows[i].ts;
         register_extract_field <= rows[i].ab;
         sequence_field <= rows[i].sf;
         memory_op_field <= rows[i].im;
         test_field <= rows[i].tf;
         condition_field <= rows[i].gf;
         op();
         check(next_addr_q, rows[i].na);
      end
      @(posedge clk);
      gr_write_bit <= 1'b1;
      special_dest_select <= 3'h1;
      alu_result <= 16'h8001;
      op();
      check(pc_q, 16'h8001);
      op();
      check(gr_a_q, 16'h8001);
      @(posedge clk);
      gr_write_bit <= 1'b1;
      b_source_class <= 2'h2;
      alu_result <= 16'h5555;
      op();
      op();
      check(gr_a_q, 16'h8001);
      ld(3'h2, 16'h00fe);
      check({shift_count_q, sc_overflow_q}, 9'h1fc);
      ld(3'h7, 16'h1111);
      check(operand_q, 16'h1111);
      ld(3'h6, 16'h000c);
      check(proc_key_q, 4'hc);
      for (int i = 0; i < 2; i++) begin
         @(posedge clk);
         sc_increment <= 1'b1;
         op();
         check({shift_count_q, sc_overflow_q}, i ? 9'h000 : 9'h1ff);
      end
      // pc never fed to the arithmetic unit here
      @(posedge clk);
      pc_increment <= 1'b1;
      pc_as_mem_addr <= 1'b1;
      op();
      check({pc_q, mem_addr_q}, 32'h8002_8002);
      check({map_high_q, map_key_q}, 8'h8c);
      reg_op(1'b1, 4'h3, 16'h00a0);
      check(io_key_q, 4'ha);
      @(posedge clk);
      pc_increment <= 1'b1;
      pc_as_mem_addr <= 1'b1;
      io_mem_op <= 1'b1;
      op();
      check({pc_q, map_key_q}, 20'h8003_a);
      uop(2'h1, 4'h2, 1'b0, 16'hbeef);
      check({mem_data_en_q, mem_data_q}, 17'h1_beef);
      uop(2'h1, 4'h2, 1'b1, 16'hcafe);
      check(mem_data_en_q, 1'b0);
      uop(2'h1, 4'h4, 1'b0, 16'h7abc);
      check({mar_q, mem_addr_q}, 32'h7abc_7abc);
      uop(2'h1, 4'h5, 1'b1, 16'h0999);
      check(mar_q, 16'h7abc);
      uop(2'h0, 4'h4, 1'b0, 16'h0123);
      check({mir_q, ibuf_q}, 32'h0123_0123);
      @(posedge clk);
      decode_select <= 1'b1;
      op();
      check(next_addr_q, 9'h0dc);
      uop(2'h0, 4'he, 1'b0, 16'h4321);
      check(ior_q, 16'h4321);
      uop(2'h0, 4'hf, 1'b1, 16'h9999);
      check(ior_q, 16'h4321);
      for (int i = 0; i < 8; i++) begin
         ld(3'h3, 16'h4002);
         @(posedge clk);
         shift_control_bit <= 1'b1;
         shift_direction_bit <= i[2];
         shift_fill_select <= i[1:0];
         alu_result <= 16'h0000;
         op();
         check(operand_q, shx[i]);
      end
      @(posedge clk);
      shift_control_bit <= 1'b1;
      b_source_class <= 2'h3;
      op();
      op();
      check(operand_q, shx[7]);
      reg_op(1'b0, 4'h0, 16'h0000);
      check(reg_rdata_q, 16'h8003);
      op();
      check(reg_rdata_q, 16'h0000);
      reg_op(1'b0, 4'hf, 16'h0000);
      check(reg_rdata_q, 16'h0000);
      reg_op(1'b1, 4'h0, 16'h1111);
      check(pc_q, 16'h8003);
      stop_test();
   end
endmodule : mds_datapath_tb
